// ==== madc_regs.vh ====
// register map, field positions, channel codes and timing constants of the converter control block
`ifndef MADC_REGS_VH
`define MADC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MADC_CTRL_ADDR 8'h00
`define MADC_SENSE_HIGH_ADDR 8'h14
`define MADC_SENSE_LOW_ADDR 8'h15
`define MADC_SUPPLY_HIGH_ADDR 8'h1E
`define MADC_SUPPLY_LOW_ADDR 8'h1F
`define MADC_AUX_HIGH_ADDR 8'h28
`define MADC_AUX_LOW_ADDR 8'h29

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define MADC_SNAPSHOT_ENABLE_BIT 7
`define MADC_SNAP_SEL_HIGH_BIT 6
`define MADC_SNAP_SEL_LOW_BIT 5
`define MADC_BUSY_BIT 3
`define MADC_CTRL_STORE_MASK 8'hF7
`define MADC_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// channel codes, shared by snapshot selection and scan order
// ----------------------------------------------------------------
`define MADC_CH_SENSE 2'h0
`define MADC_CH_SUPPLY 2'h1
`define MADC_CH_AUX 2'h2
`define MADC_CH_NONE 2'h3

// ----------------------------------------------------------------
// result layout
// ----------------------------------------------------------------
`define MADC_RESULT_RESET 12'h000
`define MADC_LOW_PAD 4'h0
`define MADC_BYTE_RESET 8'h00

// code weights per count and full-scale values, in the unit named at the end of each name
`define MADC_SENSE_LSB_NV 25000
`define MADC_SENSE_FS_UV 102400
`define MADC_SUPPLY_LSB_UV 25000
`define MADC_SUPPLY_FS_MV 102400
`define MADC_AUX_LSB_UV 500
`define MADC_AUX_FS_UV 2048000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MADC_CLK_MHZ 50
`define MADC_SCAN_PERIOD_US 133333
`define MADC_SCAN_CHANNELS 3
`define MADC_SLOT_CYCLES ((`MADC_SCAN_PERIOD_US / `MADC_SCAN_CHANNELS) * `MADC_CLK_MHZ)

`endif

// ==== madc_result_pair.v ====
// one channel's 12-bit result held as an upper byte and an upper-nibble lower byte
`timescale 1ns/1ps
`include "madc_regs.vh"

module madc_result_pair (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire hw_load,
  input wire [11:0] hw_code,
  input wire sw_wr_high,
  input wire sw_wr_low,
  input wire [7:0] sw_data,
  output wire [7:0] high_byte,
  output wire [7:0] low_byte
);

  reg [11:0] result_reg;
  reg [11:0] result_next;

  // ----------------------------------------------------------------
  // storage: a finished conversion wins over a host write
  // ----------------------------------------------------------------
  always @* begin
    result_next = result_reg;
    if (sw_wr_high) begin
      result_next[11:4] = sw_data;
    end
    if (sw_wr_low) begin
      result_next[3:0] = sw_data[7:4];
    end
    if (hw_load) begin
      result_next = hw_code;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      result_reg <= `MADC_RESULT_RESET;
    end else if (ce) begin
      result_reg <= result_next;
    end
  end

  assign high_byte = result_reg[11:4];
  assign low_byte = {result_reg[3:0], `MADC_LOW_PAD};

endmodule

// ==== madc_result_control.v ====
// result storage, scan sequencing, snapshot control and supply lockout of the measurement converter
`timescale 1ns/1ps
`include "madc_regs.vh"

module madc_result_control #(
  parameter SLOT_CYCLES = `MADC_SLOT_CYCLES,
  parameter SLOT_W = 22
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire high_supply_good,
  input wire low_supply_good,
  input wire high_supply_bus_ok,
  input wire low_supply_bus_ok,
  input wire host_wr_stb,
  input wire host_rd_stb,
  input wire [7:0] host_addr,
  input wire [7:0] host_wdata,
  input wire host_write_done,
  output wire [7:0] host_rdata,
  input wire conv_done,
  input wire [11:0] conv_code,
  output wire conv_start,
  output wire [1:0] conv_channel,
  output wire conv_enable,
  output wire bus_logic_reset,
  output wire conversion_busy_flag
);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SCAN = 4'h2;
  localparam [3:0] ST_GAP = 4'h4;
  localparam [3:0] ST_SNAP = 4'h8;
  localparam [31:0] SLOT_LAST_FULL = SLOT_CYCLES - 1;
  localparam [SLOT_W-1:0] SLOT_LAST = SLOT_LAST_FULL[SLOT_W-1:0];
  localparam [SLOT_W-1:0] SLOT_ZERO = {SLOT_W{1'b0}};
  localparam [SLOT_W-1:0] SLOT_ONE = {{(SLOT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function [7:0] high_addr;
    input [1:0] ch;
    begin
      case (ch)
        `MADC_CH_SENSE: high_addr = `MADC_SENSE_HIGH_ADDR;
        `MADC_CH_SUPPLY: high_addr = `MADC_SUPPLY_HIGH_ADDR;
        default: high_addr = `MADC_AUX_HIGH_ADDR;
      endcase
    end
  endfunction

  function [7:0] low_addr;
    input [1:0] ch;
    begin
      case (ch)
        `MADC_CH_SENSE: low_addr = `MADC_SENSE_LOW_ADDR;
        `MADC_CH_SUPPLY: low_addr = `MADC_SUPPLY_LOW_ADDR;
        default: low_addr = `MADC_AUX_LOW_ADDR;
      endcase
    end
  endfunction

  function [1:0] next_channel;
    input [1:0] ch;
    begin
      case (ch)
        `MADC_CH_SENSE: next_channel = `MADC_CH_SUPPLY;
        `MADC_CH_SUPPLY: next_channel = `MADC_CH_AUX;
        default: next_channel = `MADC_CH_SENSE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg busy_reg;
  reg busy_next;
  reg armed_reg;
  reg armed_next;
  reg snap_req_reg;
  reg snap_req_next;
  reg [1:0] snap_ch_reg;
  reg [1:0] snap_ch_next;
  reg [1:0] scan_ch_reg;
  reg [1:0] scan_ch_next;
  reg [SLOT_W-1:0] slot_cnt_reg;
  reg [SLOT_W-1:0] slot_cnt_next;
  reg start_reg;
  reg start_next;
  reg [1:0] channel_reg;
  reg [1:0] channel_next;
  reg load_stb;
  reg [1:0] load_ch;
  reg enable_reg;
  reg bus_reset_reg;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  wire ctrl_wr;
  wire [1:0] wr_sel;
  wire [7:0] res_high [0:2];
  wire [7:0] res_low [0:2];

  assign ctrl_wr = host_wr_stb && (host_addr == `MADC_CTRL_ADDR);
  assign wr_sel = {host_wdata[`MADC_SNAP_SEL_HIGH_BIT], host_wdata[`MADC_SNAP_SEL_LOW_BIT]};

  // ----------------------------------------------------------------
  // supply lockout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      enable_reg <= 1'b0;
      bus_reset_reg <= 1'b1;
    end else if (ce) begin
      // on while either supply is good, off only once both are gone
      enable_reg <= high_supply_good | low_supply_good;
      bus_reset_reg <= ~(high_supply_bus_ok | low_supply_bus_ok);
    end
  end

  // ----------------------------------------------------------------
  // control register and snapshot request
  // ----------------------------------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    armed_next = armed_reg;
    snap_req_next = snap_req_reg;
    snap_ch_next = snap_ch_reg;
    busy_next = busy_reg;
    if (ctrl_wr) begin
      ctrl_next = host_wdata & `MADC_CTRL_STORE_MASK;
      // only an enable write with a real channel arms a snapshot
      armed_next = host_wdata[`MADC_SNAPSHOT_ENABLE_BIT] && (wr_sel != `MADC_CH_NONE);
      snap_ch_next = wr_sel;
    end
    // the request ends with its own conversion; no rerun without a new write
    if (state_reg == ST_SNAP && conv_done) begin
      snap_req_next = 1'b0;
      busy_next = 1'b0;
    end
    // a new request in the same cycle wins over the clear
    if (host_write_done && armed_reg && !ctrl_wr) begin
      armed_next = 1'b0;
      snap_req_next = 1'b1;
      busy_next = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg <= `MADC_CTRL_RESET;
      armed_reg <= 1'b0;
      snap_req_reg <= 1'b0;
      snap_ch_reg <= `MADC_CH_SENSE;
      busy_reg <= 1'b0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      armed_reg <= armed_next;
      snap_req_reg <= snap_req_next;
      snap_ch_reg <= snap_ch_next;
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    scan_ch_next = scan_ch_reg;
    channel_next = channel_reg;
    start_next = 1'b0;
    load_stb = 1'b0;
    load_ch = channel_reg;
    if (slot_cnt_reg != SLOT_LAST) begin
      slot_cnt_next = slot_cnt_reg + SLOT_ONE;
    end else begin
      slot_cnt_next = slot_cnt_reg;
    end
    case (state_reg)
      ST_IDLE: begin
        if (!enable_reg) begin
          state_next = ST_IDLE;
        end else if (snap_req_reg) begin
          channel_next = snap_ch_reg;
          start_next = 1'b1;
          slot_cnt_next = SLOT_ZERO;
          state_next = ST_SNAP;
        end else if (!ctrl_reg[`MADC_SNAPSHOT_ENABLE_BIT]) begin
          channel_next = scan_ch_reg;
          start_next = 1'b1;
          slot_cnt_next = SLOT_ZERO;
          state_next = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (!enable_reg) begin
          state_next = ST_IDLE;
        end else if (conv_done) begin
          load_stb = 1'b1;
          scan_ch_next = next_channel(scan_ch_reg);
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        // pace each slot to a third of the scan period
        if (!enable_reg || snap_req_reg || slot_cnt_reg == SLOT_LAST) begin
          state_next = ST_IDLE;
        end
      end
      ST_SNAP: begin
        if (!enable_reg) begin
          state_next = ST_IDLE;
        end else if (conv_done) begin
          load_stb = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      scan_ch_reg <= `MADC_CH_SENSE;
      channel_reg <= `MADC_CH_SENSE;
      start_reg <= 1'b0;
      slot_cnt_reg <= SLOT_ZERO;
    end else if (ce) begin
      state_reg <= state_next;
      scan_ch_reg <= scan_ch_next;
      channel_reg <= channel_next;
      start_reg <= start_next;
      slot_cnt_reg <= slot_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // result register pairs, raw converter codes stored without scaling
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pair
      localparam [31:0] PAIR_IDX = gi;
      localparam [1:0] PAIR_CH = PAIR_IDX[1:0];
      madc_result_pair u_pair (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .hw_load(load_stb && (load_ch == PAIR_CH)),
        .hw_code(conv_code),
        .sw_wr_high(host_wr_stb && (host_addr == high_addr(PAIR_CH))),
        .sw_wr_low(host_wr_stb && (host_addr == low_addr(PAIR_CH))),
        .sw_data(host_wdata),
        .high_byte(res_high[gi]),
        .low_byte(res_low[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = rdata_reg;
    if (host_rd_stb) begin
      case (host_addr)
        `MADC_CTRL_ADDR: begin
          rdata_next = ctrl_reg;
          rdata_next[`MADC_BUSY_BIT] = busy_reg;
        end
        `MADC_SENSE_HIGH_ADDR: rdata_next = res_high[0];
        `MADC_SENSE_LOW_ADDR: rdata_next = res_low[0];
        `MADC_SUPPLY_HIGH_ADDR: rdata_next = res_high[1];
        `MADC_SUPPLY_LOW_ADDR: rdata_next = res_low[1];
        `MADC_AUX_HIGH_ADDR: rdata_next = res_high[2];
        `MADC_AUX_LOW_ADDR: rdata_next = res_low[2];
        default: rdata_next = `MADC_BYTE_RESET;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      rdata_reg <= `MADC_BYTE_RESET;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_rdata = rdata_reg;
  assign conv_start = start_reg;
  assign conv_channel = channel_reg;
  assign conv_enable = enable_reg;
  assign bus_logic_reset = bus_reset_reg;
  assign conversion_busy_flag = busy_reg;

endmodule

// ==== madc_ctrl_asserts.sv ====
// port assertions for the converter control block
`timescale 1ns/1ps
`include "madc_regs.vh"
module madc_ctrl_asserts #(
  parameter SLOT_CYCLES = 20,
  parameter SLOT_W = 22
) (
  input wire clk,
  input wire resetn,
  input wire high_supply_good,
  input wire low_supply_good,
  input wire high_supply_bus_ok,
  input wire low_supply_bus_ok,
  input wire host_rd_stb,
  input wire [7:0] host_addr,
  input wire host_write_done,
  input wire [7:0] host_rdata,
  input wire conv_done,
  input wire conv_start,
  input wire conv_enable,
  input wire bus_logic_reset,
  input wire conversion_busy_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_enable_on_supply: assert property ((high_supply_good || low_supply_good) |=> conv_enable)
    else $error("converter not enabled with a supply good");
  a_disable_both_low: assert property (!(high_supply_good || low_supply_good) |=> !conv_enable)
    else $error("converter enabled with both supplies low");
  a_bus_reset_both: assert property (!high_supply_bus_ok && !low_supply_bus_ok |=> bus_logic_reset)
    else $error("bus logic not reset with both supplies low");
  a_bus_run_either: assert property ((high_supply_bus_ok || low_supply_bus_ok) |=> !bus_logic_reset)
    else $error("bus logic reset with a supply above threshold");
  a_start_one_cycle: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_busy_after_done: assert property ($rose(conversion_busy_flag) |-> $past(host_write_done))
    else $error("busy set without a finished control write");
  a_busy_holds: assert property (conversion_busy_flag && !conv_done |=> conversion_busy_flag)
    else $error("busy cleared before conversion end");
  a_busy_clears_done: assert property ($fell(conversion_busy_flag) |-> $past(conv_done))
    else $error("busy cleared without a conversion end");
  a_halt_after_snap: assert property ($fell(conversion_busy_flag) |-> !conv_start [*2])
    else $error("conversion started after snapshot end");
  a_read_data_holds: assert property (!$past(host_rd_stb) |-> $stable(host_rdata))
    else $error("read data changed without a read");
  a_low_nibble_zero: assert property ($past(host_rd_stb) && ($past(host_addr) inside {`MADC_SENSE_LOW_ADDR,
    `MADC_SUPPLY_LOW_ADDR, `MADC_AUX_LOW_ADDR}) |-> host_rdata[3:0] == `MADC_LOW_PAD)
    else $error("lower result byte low nibble not zero");
  c_snap_begin: cover property ($rose(conversion_busy_flag));
  c_snap_end: cover property ($fell(conversion_busy_flag));
  c_scan_start: cover property (conv_start && !conversion_busy_flag);
  c_bus_reset: cover property ($rose(bus_logic_reset));
endmodule

bind madc_result_control madc_ctrl_asserts #(.SLOT_CYCLES(SLOT_CYCLES), .SLOT_W(SLOT_W)) u_chk (
  .clk(clk), .resetn(resetn), .high_supply_good(high_supply_good), .low_supply_good(low_supply_good),
  .high_supply_bus_ok(high_supply_bus_ok), .low_supply_bus_ok(low_supply_bus_ok), .host_rd_stb(host_rd_stb),
  .host_addr(host_addr), .host_write_done(host_write_done), .host_rdata(host_rdata), .conv_done(conv_done),
  .conv_start(conv_start), .conv_enable(conv_enable), .bus_logic_reset(bus_logic_reset),
  .conversion_busy_flag(conversion_busy_flag));

// ==== madc_host_model.sv ====
// serial-bus host model: byte writes, byte reads and end-of-write markers
`timescale 1ns/1ps
`include "madc_regs.vh"
module madc_host_model (
  input wire clk,
  output logic host_wr_stb,
  output logic host_rd_stb,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_write_done
);
  initial begin
    host_wr_stb = 1'b0;
    host_rd_stb = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_write_done = 1'b0;
  end
  // released lines show the inverse so stale values are never mistaken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    host_wr_stb = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_wr_stb = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    host_rd_stb = 1'b1;
    host_addr = a;
    @(posedge clk);
    #1;
    host_rd_stb = 1'b0;
    host_addr = ~a;
  endtask
  task automatic done();
    @(posedge clk);
    #1;
    host_write_done = 1'b1;
    @(posedge clk);
    #1;
    host_write_done = 1'b0;
  endtask
  // one write byte command per snapshot, enable bit plus channel bits
  task automatic snap(input logic [1:0] sel);
    wr(`MADC_CTRL_ADDR, {1'b1, sel, 5'h00});
    done();
  endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "madc_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  localparam int SLOT = 20;
  localparam logic [7:0] HI[3] = '{`MADC_SENSE_HIGH_ADDR, `MADC_SUPPLY_HIGH_ADDR, `MADC_AUX_HIGH_ADDR};
  localparam logic [7:0] LO[3] = '{`MADC_SENSE_LOW_ADDR, `MADC_SUPPLY_LOW_ADDR, `MADC_AUX_LOW_ADDR};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic hi_good = 1'b0;
  logic lo_good = 1'b0;
  logic hi_bus = 1'b1;
  logic lo_bus = 1'b1;
  logic conv_done = 1'b0;
  logic [11:0] conv_code = 12'h000;
  wire wr_stb, rd_stb, wr_done, conv_start, conv_enable, bus_logic_reset, busy;
  wire [7:0] addr, wdata, rdata;
  wire [1:0] conv_channel;
  int fails = 0;
  int compares = 0;
  int nstart = 0;
  logic [15:0] lfsr_q = 16'h002C;
  logic [7:0] expq[$];
  logic rd_pend = 1'b0;
  logic snap = 1'b0;
  logic [1:0] exp_ch = `MADC_CH_SENSE;
  logic [11:0] code_of[0:3];
  logic [7:0] exp_rd;
  logic [1:0] cur_ch;

  initial begin
    forever #10 clk = ~clk;
  end

  madc_host_model host (.clk(clk), .host_wr_stb(wr_stb), .host_rd_stb(rd_stb), .host_addr(addr),
    .host_wdata(wdata), .host_write_done(wr_done));
  madc_result_control #(.SLOT_CYCLES(SLOT)) dut (.clk(clk), .resetn(resetn), .ce(ce),
    .high_supply_good(hi_good), .low_supply_good(lo_good), .high_supply_bus_ok(hi_bus),
    .low_supply_bus_ok(lo_bus), .host_wr_stb(wr_stb), .host_rd_stb(rd_stb), .host_addr(addr),
    .host_wdata(wdata), .host_write_done(wr_done), .host_rdata(rdata), .conv_done(conv_done),
    .conv_code(conv_code), .conv_start(conv_start), .conv_channel(conv_channel), .conv_enable(conv_enable),
    .bus_logic_reset(bus_logic_reset), .conversion_busy_flag(busy));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic summarize();
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.rd(a);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (busy !== lvl) begin
      fails++;
      summarize();
    end
  endtask

  // read data monitor: oldest expectation against each answer
  always @(posedge clk) begin
    if (rd_pend) begin
      exp_rd = expq.pop_front();
      `CHK(rdata, exp_rd)
    end
    rd_pend <= rd_stb;
  end

  // converter model: random codes after a random conversion time
  initial begin
    forever begin
      @(posedge clk);
      if (conv_start === 1'b1) begin
        nstart++;
        `CHK(conv_channel, exp_ch)
        cur_ch = exp_ch;
        if (!snap) exp_ch = (exp_ch == `MADC_CH_AUX) ? `MADC_CH_SENSE : exp_ch + 2'h1;
        lfsr_q = lfsr(lfsr_q);
        repeat (2 + lfsr_q[1:0]) @(posedge clk);
        #1;
        conv_done = 1'b1;
        conv_code = lfsr_q[11:0];
        code_of[cur_ch] = lfsr_q[11:0];
        @(posedge clk);
        #1;
        conv_done = 1'b0;
        conv_code = ~conv_code;
      end
    end
  end

  initial begin
    int k;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    rd_chk(`MADC_CTRL_ADDR, `MADC_CTRL_RESET);
    for (int i = 0; i < 3; i++) begin
      rd_chk(HI[i], `MADC_BYTE_RESET);
      rd_chk(LO[i], `MADC_BYTE_RESET);
    end
    rd_chk(8'h01, 8'h00);
    `CHK(conv_enable, 1'b0)
    lo_good = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(conv_enable, 1'b1)
    k = 0;
    while (nstart < 7 && k < 400) begin
      @(posedge clk);
      k++;
    end
    `CHK(nstart >= 7, 1'b1)
    if (nstart < 7) summarize();
    host.wr(`MADC_CTRL_ADDR, 8'hE8);
    repeat (SLOT) @(posedge clk);
    rd_chk(`MADC_CTRL_ADDR, 8'hE0);
    snap = 1'b1;
    for (int s = 0; s < 3; s++) begin
      exp_ch = s[1:0];
      k = nstart;
      host.snap(s[1:0]);
      wait_busy(1'b1, 4);
      rd_chk(`MADC_CTRL_ADDR, {1'b1, s[1:0], 2'b01, 3'h0});
      wait_busy(1'b0, 40);
      `CHK(nstart - k, 1)
      repeat (30) @(posedge clk);
      `CHK(nstart - k, 1)
      rd_chk(HI[s], code_of[s][11:4]);
      rd_chk(LO[s], {code_of[s][3:0], `MADC_LOW_PAD});
    end
    host.wr(`MADC_AUX_LOW_ADDR, 8'h5A);
    rd_chk(`MADC_AUX_LOW_ADDR, 8'h50);
    host.wr(`MADC_AUX_HIGH_ADDR, 8'hC3);
    rd_chk(`MADC_AUX_HIGH_ADDR, 8'hC3);
    ce = 1'b0;
    host.wr(`MADC_AUX_HIGH_ADDR, 8'h3C);
    ce = 1'b1;
    rd_chk(`MADC_AUX_HIGH_ADDR, 8'hC3);
    hi_good = 1'b1;
    lo_good = 1'b0;
    lo_bus = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(conv_enable, 1'b1)
    `CHK(bus_logic_reset, 1'b0)
    hi_good = 1'b0;
    hi_bus = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(conv_enable, 1'b0)
    `CHK(bus_logic_reset, 1'b1)
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
